//--- core/pcoc_top.sv
// Purpose: executes decoded instructions whose operand is the program counter or stack
//          pointer, either as the silicon does or as the corrected reference
// Assumes: one instruction per accepted in_valid, operand values supplied by the core
// Notes:   deviate high models the silicon, low gives the reference behaviour
`timescale 1ns/1ps
`include "pcoc_defs.svh"
module pcoc_top (
    input  wire logic                 mclk,
    input  wire logic                 reset,
    input  wire logic                 deviate,
    input  wire logic                 in_valid,
    output logic                      in_ready,
    input  wire pcoc_pkg::pcoc_op_t   in_op,
    input  wire pcoc_pkg::pcoc_mode_t in_src_mode,
    input  wire pcoc_pkg::pcoc_reg_t  in_src_reg,
    input  wire pcoc_pkg::pcoc_reg_t  in_dst_reg,
    input  wire pcoc_pkg::pcoc_addr_t in_addr,
    input  wire pcoc_pkg::pcoc_addr_t in_src,
    input  wire pcoc_pkg::pcoc_addr_t in_reg_val,
    input  wire pcoc_pkg::pcoc_addr_t in_sp,
    input  wire logic                 in_jump_taken,
    output logic                      out_valid,
    output pcoc_pkg::pcoc_len_t       out_len,
    output pcoc_pkg::pcoc_addr_t      out_pc_operand,
    output pcoc_pkg::pcoc_addr_t      out_result,
    output logic                      out_wr_dest,
    output pcoc_pkg::pcoc_flags_t     out_flags,
    output pcoc_pkg::pcoc_addr_t      out_sp,
    output pcoc_pkg::pcoc_addr_t      out_push_data,
    output pcoc_pkg::pcoc_addr_t      out_target,
    output logic                      out_deviated,
    output logic                      halted
);
    import pcoc_pkg::*;

    pcoc_dec_if dec_if ();

    pcoc_classify u_classify (
        .d (dec_if)
    );

    assign dec_if.op       = in_op;
    assign dec_if.src_mode = in_src_mode;
    assign dec_if.src_reg  = in_src_reg;
    assign dec_if.dst_reg  = in_dst_reg;

    logic        accept;
    logic        prev_push_mem;
    logic        prev_jump_not_taken;
    logic        halt_now;
    pcoc_addr_t  pc_ref;
    pcoc_addr_t  next_pc_operand;
    pcoc_addr_t  next_result;
    logic        next_wr_dest;
    pcoc_flags_t next_flags;
    pcoc_addr_t  next_sp;
    pcoc_addr_t  next_push_data;
    pcoc_addr_t  next_target;
    logic        next_deviated;
    pcoc_addr_t  op_a;
    pcoc_addr_t  op_b;
    logic [20:0] sum;
    pcoc_addr_t  bit_res;

    // a halted core takes nothing more until reset
    assign in_ready = !halted;
    assign accept   = in_valid && !halted;
    assign halt_now = deviate && prev_jump_not_taken && dec_if.rot_pc;

    always_comb begin
        pc_ref          = in_addr + pcoc_addr_t'(dec_if.len);
        next_pc_operand = pc_ref;
        next_result     = in_reg_val;
        next_wr_dest    = 1'b0;
        next_flags      = '0;
        next_sp         = in_sp;
        next_push_data  = '0;
        next_target     = '0;
        next_deviated   = 1'b0;
        op_a            = '0;
        op_b            = '0;
        sum             = '0;
        bit_res         = '0;
        case (in_op)
            OP_MOVA: begin
                // move never reads the PC as a source, so no short count
                next_result  = in_src;
                next_wr_dest = 1'b1;
            end
            OP_ADDRESS_ADD_INSTR, OP_ADDRESS_SUBTRACT_INSTR, OP_ADDRESS_COMPARE_INSTR, OP_ADDX, OP_SUBX, OP_CMPX: begin
                if (dec_if.addr_imm_pc && deviate) begin
                    next_pc_operand = pc_ref - `PCOC_PC_SHORT;
                    next_deviated   = 1'b1;
                end
                // extended forms take the full length and stay correct
                op_a = (in_dst_reg == `PCOC_PC_REG) ? next_pc_operand : in_reg_val;
                op_b = in_src;
                if ((in_op == OP_ADDRESS_ADD_INSTR) || (in_op == OP_ADDX)) begin
                    sum = {1'b0, op_a} + {1'b0, op_b};
                    next_flags[`PCOC_FLAG_V] = (op_a[`PCOC_ADDR_MSB] == op_b[`PCOC_ADDR_MSB]) &&
                                               (sum[`PCOC_ADDR_MSB] != op_a[`PCOC_ADDR_MSB]);
                end else begin
                    sum = {1'b0, op_a} + {1'b0, ~op_b} + `PCOC_ONE;
                    next_flags[`PCOC_FLAG_V] = (op_a[`PCOC_ADDR_MSB] != op_b[`PCOC_ADDR_MSB]) &&
                                               (sum[`PCOC_ADDR_MSB] != op_a[`PCOC_ADDR_MSB]);
                end
                next_result              = sum[`PCOC_ADDR_MSB:0];
                next_wr_dest             = (in_op != OP_ADDRESS_COMPARE_INSTR) && (in_op != OP_CMPX);
                next_flags[`PCOC_FLAG_N] = sum[`PCOC_ADDR_MSB];
                next_flags[`PCOC_FLAG_Z] = (sum[`PCOC_ADDR_MSB:0] == '0);
                next_flags[`PCOC_FLAG_C] = sum[`PCOC_CARRY_BIT];
            end
            OP_PUSH, OP_EXTENDED_PUSH_INSTR: begin
                next_push_data = in_src;
                if (dec_if.wide_push_sp_inc && deviate) begin
                    next_sp       = in_src;
                    next_deviated = 1'b1;
                end else begin
                    next_sp = in_sp - `PCOC_SP_STEP;
                end
            end
            OP_ADDRESS_CALL_INSTR: begin
                next_sp        = in_sp - `PCOC_SP_STEP;
                next_push_data = pc_ref;
                if (dec_if.address_call_instr_pc) begin
                    next_target = pc_ref;
                    if (deviate) begin
                        next_push_data = pc_ref - `PCOC_RET_SHORT;
                        next_deviated  = 1'b1;
                    end
                end else if (dec_if.address_call_instr_idx) begin
                    // only the SP base after a memory-mode push loses the sign
                    if (deviate && dec_if.address_call_instr_idx_sp && prev_push_mem) begin
                        next_target   = in_reg_val + pcoc_addr_t'(in_src[`PCOC_IDX_MSB:0]);
                        next_deviated = in_src[`PCOC_IDX_MSB];
                    end else begin
                        next_target = in_reg_val + pcoc_addr_t'($signed(in_src[`PCOC_IDX_MSB:0]));
                    end
                end else begin
                    next_target = in_src;
                end
            end
            OP_ROTA: begin
                op_a         = (in_dst_reg == `PCOC_PC_REG) ? pc_ref : in_reg_val;
                next_result  = {op_a[`PCOC_ADDR_MSB], op_a[`PCOC_ADDR_MSB:1]};
                next_wr_dest = 1'b1;
                next_flags[`PCOC_FLAG_C] = op_a[0];
            end
            OP_BIT: begin
                op_a = (in_dst_reg == `PCOC_PC_REG) ? pc_ref : in_reg_val;
                if (dec_if.bit_ind_pc && deviate) begin
                    op_a          = in_addr;
                    next_deviated = 1'b1;
                end
                next_pc_operand = op_a;
                bit_res         = op_a & in_src;
                next_result     = bit_res;
                next_flags[`PCOC_FLAG_N] = bit_res[`PCOC_WORD_MSB];
                next_flags[`PCOC_FLAG_Z] = (bit_res[`PCOC_WORD_MSB:0] == '0);
                next_flags[`PCOC_FLAG_C] = (bit_res[`PCOC_WORD_MSB:0] != '0);
            end
            default: begin
                next_result = in_reg_val;
            end
        endcase
    end

    // pairing history: only the instruction just before counts, a no-op clears it
    always_ff @(posedge mclk) begin
        if (reset) begin
            prev_push_mem       <= 1'b0;
            prev_jump_not_taken <= 1'b0;
        end else if (accept) begin
            prev_push_mem       <= dec_if.push_mem;
            prev_jump_not_taken <= dec_if.jcond && !in_jump_taken;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            halted <= 1'b0;
        end else if (accept && halt_now) begin
            halted <= 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            out_valid <= 1'b0;
        end else begin
            out_valid <= accept && !halt_now;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            out_len        <= '0;
            out_pc_operand <= '0;
            out_result     <= '0;
            out_wr_dest    <= 1'b0;
            out_flags      <= '0;
            out_sp         <= '0;
            out_push_data  <= '0;
            out_target     <= '0;
            out_deviated   <= 1'b0;
        end else if (accept && !halt_now) begin
            out_len        <= dec_if.len;
            out_pc_operand <= next_pc_operand;
            out_result     <= next_result;
            out_wr_dest    <= next_wr_dest;
            out_flags      <= next_flags;
            out_sp         <= next_sp;
            out_push_data  <= next_push_data;
            out_target     <= next_target;
            out_deviated   <= next_deviated;
        end
    end

endmodule

//--- core/pcoc_defs.svh
// Purpose: named constants for the program-counter operand corner-case decoder
// Assumes: 20-bit address space, 16-bit instruction words
// Notes:   definitions only
`ifndef PCOC_DEFS_SVH
`define PCOC_DEFS_SVH

`define PCOC_PC_REG      4'h0
`define PCOC_SP_REG      4'h1

`define PCOC_LEN_2       3'h2
`define PCOC_LEN_4       3'h4
`define PCOC_LEN_6       3'h6

`define PCOC_PC_SHORT    20'h00002
`define PCOC_RET_SHORT   20'h00002
`define PCOC_SP_STEP     20'h00004
`define PCOC_ONE         21'h000001

`define PCOC_IDX_MSB     15
`define PCOC_WORD_MSB    15
`define PCOC_ADDR_MSB    19
`define PCOC_CARRY_BIT   20

`define PCOC_FLAG_V      3
`define PCOC_FLAG_N      2
`define PCOC_FLAG_Z      1
`define PCOC_FLAG_C      0

`endif

//--- core/pcoc_pkg.sv
// Purpose: types shared by the decoder and its classifier
// Assumes: nothing beyond the constants header
// Notes:   operation classes are already decoded from the instruction stream
package pcoc_pkg;

    typedef logic [19:0] pcoc_addr_t;
    typedef logic [3:0]  pcoc_reg_t;
    typedef logic [2:0]  pcoc_len_t;
    typedef logic [3:0]  pcoc_flags_t;

    typedef enum logic [3:0] {
        OP_OTHER, OP_NOP, OP_MOVA, OP_ADDRESS_ADD_INSTR, OP_ADDRESS_SUBTRACT_INSTR, OP_ADDRESS_COMPARE_INSTR,
        OP_ADDX, OP_SUBX, OP_CMPX, OP_PUSH, OP_EXTENDED_PUSH_INSTR, OP_ADDRESS_CALL_INSTR,
        OP_JCOND, OP_ROTA, OP_BIT
    } pcoc_op_t;

    typedef enum logic [2:0] {
        MODE_REG, MODE_IDX, MODE_SYM, MODE_ABS, MODE_IND, MODE_INC, MODE_IMM
    } pcoc_mode_t;

endpackage

//--- core/pcoc_dec_if.sv
// Purpose: carries instruction fields to the classifier and its verdicts back
// Assumes: purely combinational traffic
// Notes:   one instance per decoder
`timescale 1ns/1ps
interface pcoc_dec_if;
    import pcoc_pkg::*;
    pcoc_op_t   op;
    pcoc_mode_t src_mode;
    pcoc_reg_t  src_reg;
    pcoc_reg_t  dst_reg;
    pcoc_len_t  len;
    logic       addr_imm_pc;
    logic       mova_pc;
    logic       wide_push_sp_inc;
    logic       address_call_instr_pc;
    logic       address_call_instr_idx;
    logic       address_call_instr_idx_sp;
    logic       push_mem;
    logic       jcond;
    logic       rot_pc;
    logic       bit_ind_pc;

    modport dec (input op, src_mode, src_reg, dst_reg,
                 output len, addr_imm_pc, mova_pc, wide_push_sp_inc, address_call_instr_pc, address_call_instr_idx,
                 address_call_instr_idx_sp, push_mem, jcond, rot_pc, bit_ind_pc);
    modport use_side (output op, src_mode, src_reg, dst_reg,
                      input len, addr_imm_pc, mova_pc, wide_push_sp_inc, address_call_instr_pc, address_call_instr_idx,
                      address_call_instr_idx_sp, push_mem, jcond, rot_pc, bit_ind_pc);
endinterface

//--- core/pcoc_classify.sv
// Purpose: opcode length and corner-case classification of one instruction
// Assumes: fields stable while sampled by the decoder
// Notes:   purely combinational
`timescale 1ns/1ps
`include "pcoc_defs.svh"
module pcoc_classify (
    pcoc_dec_if.dec d
);
    import pcoc_pkg::*;

    logic ext_word;
    logic mem_mode;

    always_comb begin
        ext_word = (d.src_mode == MODE_IDX) || (d.src_mode == MODE_SYM) ||
                   (d.src_mode == MODE_ABS) || (d.src_mode == MODE_IMM);
        mem_mode = (d.src_mode == MODE_IDX) || (d.src_mode == MODE_SYM) ||
                   (d.src_mode == MODE_ABS) || (d.src_mode == MODE_IND) ||
                   (d.src_mode == MODE_INC);
        case (d.op)
            OP_MOVA, OP_ADDRESS_ADD_INSTR, OP_ADDRESS_SUBTRACT_INSTR, OP_ADDRESS_COMPARE_INSTR: d.len = (d.src_mode == MODE_IMM) ? `PCOC_LEN_4 : `PCOC_LEN_2;
            OP_ADDX, OP_SUBX, OP_CMPX:          d.len = ext_word ? `PCOC_LEN_6 : `PCOC_LEN_4;
            OP_PUSH, OP_ADDRESS_CALL_INSTR:                  d.len = ext_word ? `PCOC_LEN_4 : `PCOC_LEN_2;
            OP_EXTENDED_PUSH_INSTR:                           d.len = ext_word ? `PCOC_LEN_6 : `PCOC_LEN_4;
            default:                            d.len = `PCOC_LEN_2;
        endcase
        d.addr_imm_pc      = ((d.op == OP_ADDRESS_ADD_INSTR) || (d.op == OP_ADDRESS_SUBTRACT_INSTR) || (d.op == OP_ADDRESS_COMPARE_INSTR)) &&
                             (d.src_mode == MODE_IMM) && (d.dst_reg == `PCOC_PC_REG);
        d.mova_pc          = (d.op == OP_MOVA) && (d.dst_reg == `PCOC_PC_REG);
        d.wide_push_sp_inc = (d.op == OP_EXTENDED_PUSH_INSTR) && (d.src_mode == MODE_INC) &&
                             (d.src_reg == `PCOC_SP_REG);
        d.address_call_instr_pc         = (d.op == OP_ADDRESS_CALL_INSTR) && (d.src_mode == MODE_REG) &&
                             (d.src_reg == `PCOC_PC_REG);
        d.address_call_instr_idx        = (d.op == OP_ADDRESS_CALL_INSTR) && (d.src_mode == MODE_IDX);
        d.address_call_instr_idx_sp     = d.address_call_instr_idx && (d.src_reg == `PCOC_SP_REG);
        d.push_mem         = ((d.op == OP_PUSH) || (d.op == OP_EXTENDED_PUSH_INSTR)) && mem_mode;
        d.jcond            = (d.op == OP_JCOND);
        d.rot_pc           = (d.op == OP_ROTA) && (d.dst_reg == `PCOC_PC_REG);
        d.bit_ind_pc       = (d.op == OP_BIT) && (d.src_mode == MODE_IND) &&
                             (d.dst_reg == `PCOC_PC_REG);
    end

endmodule

//--- dv/pcoc_top_sva.sv
// Purpose: port-level checks of the pc operand corner-case decoder
// Assumes: bound to pcoc_top, one mclk domain
// Notes:   history bit mirrors the previous accepted instruction only
`timescale 1ns/1ps
module pcoc_top_sva (
    input wire logic                 mclk,
    input wire logic                 reset,
    input wire logic                 deviate,
    input wire logic                 in_valid,
    input wire logic                 in_ready,
    input wire pcoc_pkg::pcoc_op_t   in_op,
    input wire pcoc_pkg::pcoc_mode_t in_src_mode,
    input wire pcoc_pkg::pcoc_reg_t  in_src_reg,
    input wire pcoc_pkg::pcoc_reg_t  in_dst_reg,
    input wire pcoc_pkg::pcoc_addr_t in_addr,
    input wire pcoc_pkg::pcoc_addr_t in_src,
    input wire pcoc_pkg::pcoc_addr_t in_sp,
    input wire logic                 in_jump_taken,
    input wire logic                 out_valid,
    input wire pcoc_pkg::pcoc_len_t  out_len,
    input wire pcoc_pkg::pcoc_addr_t out_pc_operand,
    input wire pcoc_pkg::pcoc_addr_t out_result,
    input wire pcoc_pkg::pcoc_addr_t out_sp,
    input wire pcoc_pkg::pcoc_addr_t out_push_data,
    input wire logic                 halted
);
    import pcoc_pkg::*;
    logic take;
    logic prev_untaken;
    logic rot_pc;
    assign take = in_valid && in_ready;
    assign rot_pc = take && in_op == OP_ROTA && in_dst_reg == 4'h0;
    always_ff @(posedge mclk) begin
        if (reset) begin
            prev_untaken <= 1'b0;
        end else if (take) begin
            prev_untaken <= in_op == OP_JCOND && !in_jump_taken;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    ready_tracks_halt_a: assert property (in_ready == !halted)
        else $error("ready not inverse of halt");
    halt_sticky_a: assert property (halted |=> halted)
        else $error("halt released without reset");
    halt_entry_a: assert property (rot_pc && prev_untaken && deviate |=> halted && !out_valid)
        else $error("jump then pc rotate did not halt");
    answer_next_a: assert property (take && !(rot_pc && prev_untaken && deviate) |=> out_valid && !halted)
        else $error("accepted instruction gave no answer");
    addr_len_a: assert property (
        take && in_op inside {OP_ADDRESS_ADD_INSTR, OP_ADDRESS_SUBTRACT_INSTR, OP_ADDRESS_COMPARE_INSTR} && in_src_mode == MODE_IMM |=> out_len == 3'h4)
        else $error("address immediate length wrong");
    addr_pc_a: assert property (take && in_op inside {OP_ADDRESS_ADD_INSTR, OP_ADDRESS_SUBTRACT_INSTR, OP_ADDRESS_COMPARE_INSTR} &&
        in_src_mode == MODE_IMM && in_dst_reg == 4'h0
        |=> out_pc_operand == $past(in_addr) + ($past(deviate) ? 20'h00002 : 20'h00004))
        else $error("address immediate pc operand wrong");
    move_pc_a: assert property (take && in_op == OP_MOVA && in_dst_reg == 4'h0
        |=> out_pc_operand == $past(in_addr) + ($past(in_src_mode) == MODE_IMM ? 20'h00004 : 20'h00002) &&
            out_result == $past(in_src))
        else $error("move to pc offset wrongly");
    push_sp_a: assert property (take && in_op == OP_EXTENDED_PUSH_INSTR && in_src_mode == MODE_INC && in_src_reg == 4'h1
        |=> out_sp == ($past(deviate) ? $past(in_src) : $past(in_sp) - 20'h00004))
        else $error("wide push stack pointer wrong");
    call_ret_a: assert property (take && in_op == OP_ADDRESS_CALL_INSTR && in_src_mode == MODE_REG && in_src_reg == 4'h0
        |=> out_push_data == $past(in_addr) + ($past(deviate) ? 20'h00000 : 20'h00002))
        else $error("call through pc return address wrong");
    bit_pc_a: assert property (take && in_op == OP_BIT && in_src_mode == MODE_IND && in_dst_reg == 4'h0
        |=> out_pc_operand == $past(in_addr) + ($past(deviate) ? 20'h00000 : 20'h00002))
        else $error("bit test pc operand wrong");
endmodule
bind pcoc_top pcoc_top_sva u_sva (.mclk(mclk), .reset(reset), .deviate(deviate), .in_valid(in_valid),
    .in_ready(in_ready), .in_op(in_op), .in_src_mode(in_src_mode), .in_src_reg(in_src_reg),
    .in_dst_reg(in_dst_reg), .in_addr(in_addr), .in_src(in_src), .in_sp(in_sp), .in_jump_taken(in_jump_taken),
    .out_valid(out_valid), .out_len(out_len), .out_pc_operand(out_pc_operand), .out_result(out_result),
    .out_sp(out_sp), .out_push_data(out_push_data), .halted(halted));

//--- dv/test_pcoc_top.sv
// Purpose: directed scenarios for the pc operand corner-case decoder
// Assumes: inputs change on falling mclk, answers read one cycle later
// Notes:   expectations are computed here, never read back from the design
`timescale 1ns/1ps
module test_pcoc_top;
    import pcoc_pkg::*;
    logic       mclk, reset, deviate, in_valid, in_ready, in_jump_taken, out_valid, out_wr_dest, out_deviated, halted;
    pcoc_op_t   in_op;
    pcoc_mode_t in_src_mode;
    pcoc_reg_t  in_src_reg, in_dst_reg;
    pcoc_addr_t in_addr, in_src, in_reg_val, in_sp, out_pc_operand, out_result, out_sp, out_push_data, out_target;
    pcoc_len_t  out_len;
    pcoc_flags_t out_flags;
    int         mismatches, num_checks, cycles;
    pcoc_top dut (.mclk(mclk), .reset(reset), .deviate(deviate), .in_valid(in_valid), .in_ready(in_ready),
        .in_op(in_op), .in_src_mode(in_src_mode), .in_src_reg(in_src_reg), .in_dst_reg(in_dst_reg),
        .in_addr(in_addr), .in_src(in_src), .in_reg_val(in_reg_val), .in_sp(in_sp), .in_jump_taken(in_jump_taken),
        .out_valid(out_valid), .out_len(out_len), .out_pc_operand(out_pc_operand), .out_result(out_result),
        .out_wr_dest(out_wr_dest), .out_flags(out_flags), .out_sp(out_sp), .out_push_data(out_push_data),
        .out_target(out_target), .out_deviated(out_deviated), .halted(halted));
    always #2.5 mclk = ~mclk;
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            wrap_up();
        end
    end
    task automatic chk(input string name, input logic [19:0] seen, input logic [19:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // holds in_valid up so back-to-back issues never toggle it twice in one step
    task automatic issue(input pcoc_op_t op, input pcoc_mode_t md, input pcoc_reg_t sr, input pcoc_reg_t dr,
                         input pcoc_addr_t a, input pcoc_addr_t s, input pcoc_addr_t rv);
        in_valid = 1'b1;
        in_op = op;
        in_src_mode = md;
        in_src_reg = sr;
        in_dst_reg = dr;
        in_addr = a;
        in_src = s;
        in_reg_val = rv;
        @(negedge mclk);
    endtask
    task automatic do_reset();
        in_valid = 1'b0;
        reset = 1'b1;
        repeat (5) @(negedge mclk);
        reset = 1'b0;
        @(negedge mclk);
    endtask
    task automatic t_addr();
        pcoc_op_t   ops[3] = '{OP_ADDRESS_ADD_INSTR, OP_ADDRESS_SUBTRACT_INSTR, OP_ADDRESS_COMPARE_INSTR};
        pcoc_addr_t pc;
        for (int d = 0; d < 2; d++) begin
            for (int i = 0; i < 3; i++) begin
                deviate = d[0];
                issue(ops[i], MODE_IMM, 4'h2, 4'h0, 20'h0FFFE, 20'h00010, 20'h00000);
                pc = 20'h0FFFE + (d == 1 ? 20'h00002 : 20'h00004);
                chk("len", 20'(out_len), 20'h00004);
                chk("pc", out_pc_operand, pc);
                chk("res", out_result, i == 0 ? pc + 20'h00010 : pc - 20'h00010);
                chk("wr", 20'(out_wr_dest), i == 2 ? 20'h0 : 20'h1);
                chk("dev", 20'(out_deviated), 20'(d));
            end
        end
        issue(OP_ADDX, MODE_IMM, 4'h2, 4'h0, 20'h0FFFE, 20'h00010, 20'h00000);
        chk("xpc", out_pc_operand, 20'h10004);
        chk("xdev", 20'(out_deviated), 20'h0);
        issue(OP_MOVA, MODE_IMM, 4'h2, 4'h0, 20'h04000, 20'h12345, 20'h00000);
        chk("mov", out_result, 20'h12345);
        chk("movpc", out_pc_operand, 20'h04004);
        chk("movdev", 20'(out_deviated), 20'h0);
        $display("address arithmetic done");
    endtask
    task automatic t_push_call();
        in_sp = 20'h02400;
        for (int d = 1; d >= 0; d--) begin
            deviate = d[0];
            issue(OP_EXTENDED_PUSH_INSTR, MODE_INC, 4'h1, 4'h0, 20'h05000, 20'h0ABCD, 20'h00000);
            chk("sp", out_sp, d == 1 ? 20'h0ABCD : 20'h023FC);
            issue(OP_ADDRESS_CALL_INSTR, MODE_REG, 4'h0, 4'h0, 20'h06000, 20'h00000, 20'h00000);
            chk("ret", out_push_data, d == 1 ? 20'h06000 : 20'h06002);
            chk("tgt", out_target, 20'h06002);
        end
        $display("push and call done");
    endtask
    task automatic t_index();
        pcoc_op_t   pop[7] = '{OP_PUSH, OP_EXTENDED_PUSH_INSTR, OP_PUSH, OP_PUSH, OP_PUSH, OP_PUSH, OP_EXTENDED_PUSH_INSTR};
        pcoc_mode_t pmd[7] = '{MODE_IDX, MODE_ABS, MODE_SYM, MODE_REG, MODE_IMM, MODE_IND, MODE_INC};
        pcoc_reg_t  base[7] = '{4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h5, 4'h1};
        logic [6:0] zx = 7'b0000111;
        deviate = 1'b1;
        for (int i = 0; i < 7; i++) begin
            issue(pop[i], pmd[i], 4'h6, 4'h0, 20'h07000, 20'h01111, 20'h00000);
            if (i == 6) issue(OP_NOP, MODE_REG, 4'h0, 4'h3, 20'h07004, 20'h00000, 20'h00000);
            issue(OP_ADDRESS_CALL_INSTR, MODE_IDX, base[i], 4'h0, 20'h07006, 20'h0FFFC, 20'h03000);
            chk("itgt", out_target, zx[i] ? 20'h12FFC : 20'h02FFC);
            chk("idev", 20'(out_deviated), 20'(zx[i]));
        end
        $display("indexed call done");
    endtask
    task automatic t_bit();
        for (int d = 1; d >= 0; d--) begin
            deviate = d[0];
            issue(OP_BIT, MODE_IND, 4'h4, 4'h0, 20'h08000, 20'h00002, 20'h00000);
            chk("bpc", out_pc_operand, d == 1 ? 20'h08000 : 20'h08002);
            chk("bflg", 20'(out_flags), d == 1 ? 20'h2 : 20'h1);
            chk("bwr", 20'(out_wr_dest), 20'h0);
        end
        $display("bit test done");
    endtask
    task automatic jr(input logic tk, input logic nop, input pcoc_reg_t dr, input logic dv, input logic hx);
        deviate = dv;
        in_jump_taken = tk;
        issue(OP_JCOND, MODE_REG, 4'h0, 4'h0, 20'h09000, 20'h00000, 20'h00000);
        if (nop) issue(OP_NOP, MODE_REG, 4'h0, 4'h3, 20'h09002, 20'h00000, 20'h00000);
        issue(OP_ROTA, MODE_REG, 4'h0, dr, 20'h09004, 20'h00000, 20'h80002);
        chk("halt", 20'(halted), 20'(hx));
        chk("valid", 20'(out_valid), 20'(!hx));
    endtask
    task automatic t_halt();
        jr(1'b1, 1'b0, 4'h0, 1'b1, 1'b0);
        jr(1'b0, 1'b1, 4'h0, 1'b1, 1'b0);
        jr(1'b0, 1'b0, 4'h5, 1'b1, 1'b0);
        jr(1'b0, 1'b0, 4'h0, 1'b0, 1'b0);
        jr(1'b0, 1'b0, 4'h0, 1'b1, 1'b1);
        issue(OP_MOVA, MODE_REG, 4'h2, 4'h3, 20'h0A000, 20'h00001, 20'h00000);
        chk("refused", 20'(out_valid), 20'h0);
        chk("ready", 20'(in_ready), 20'h0);
        do_reset();
        chk("rdy_rst", 20'(in_ready), 20'h1);
        $display("halt sequence done");
    endtask
    initial begin
        mclk = 1'b0;
        {deviate, in_valid, in_jump_taken} = 3'h0;
        in_op = OP_NOP;
        in_src_mode = MODE_REG;
        {in_src_reg, in_dst_reg} = 8'h00;
        {in_addr, in_src, in_reg_val, in_sp} = 80'h0;
        mismatches = 0;
        num_checks = 0;
        cycles = 0;
        do_reset();
        t_addr();
        t_push_call();
        t_index();
        t_bit();
        t_halt();
        wrap_up();
    end
endmodule
